// [shared/modem_regs_pkg.sv]
package modem_regs_pkg;

  // modem-bus register indices (3-bit address)
  localparam logic [2:0] MADDR_TONE = 3'h4;
  localparam logic [2:0] MADDR_LINE = 3'h5;
  localparam logic [2:0] MADDR_SCRATCH = 3'h6;
  localparam logic [2:0] MADDR_HANDSHAKE = 3'h7;
  localparam logic [2:0] MADDR_CTRL_TWO = 3'h2;
  // uart-bus register indices (4-bit address)
  localparam logic [3:0] UADDR_LINE = 4'hd;
  localparam logic [3:0] UADDR_SCRATCH = 4'he;
  localparam logic [3:0] UADDR_HANDSHAKE = 4'hf;

  // tone register fields
  localparam int TONE_SEL_LSB = 0;
  localparam int TONE_SEL_W = 4;
  localparam int TONE_VARIANT_BIT = 0;
  localparam int TONE_PAIR_BIT = 4;
  localparam int TONE_ANSWER_BIT = 5;
  localparam int TONE_GUARD_BIT = 6;
  localparam int TONE_ROUTE_BIT = 7;
  // line control fields
  localparam int LINE_HOOK_BIT = 5;
  localparam int LINE_VOL_LSB = 6;
  localparam logic [7:0] LINE_USED_MASK = 8'he0;
  // handshake fields
  localparam int HS_STATUS_W = 4;
  localparam int HS_CTS_BIT = 0;
  localparam int HS_DSR_BIT = 1;
  localparam int HS_DCD_BIT = 2;
  localparam int HS_RI_BIT = 3;
  localparam int HS_DTR_BIT = 4;
  localparam int HS_RTS_BIT = 5;
  localparam int HS_CLK_BIT = 7;

  // reset values
  localparam logic [7:0] TONE_RST = 8'h00;
  localparam logic [7:0] LINE_RST = 8'h00;
  localparam logic [7:0] SCRATCH_RST = 8'h00;
  localparam logic [3:0] HS_STATUS_RST = 4'h0;

  // speaker levels
  typedef enum logic [1:0] {
    SPK_OFF = 2'h0,
    SPK_M24 = 2'h1,
    SPK_M12 = 2'h2,
    SPK_0DB = 2'h3
  } spk_level_t;

  // transmit source chosen for the analog section
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_PAIR = 5'h02,
    ANSWER_TONE_TRANSMIT_2225 = 5'h04,
    ANSWER_TONE_TRANSMIT_2100 = 5'h08,
    TX_GUARD = 5'h10
  } tx_src_t;

  // a register-bus access
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  // modem status handed to the uart
  typedef struct packed {
    logic cts;
    logic dsr;
    logic dcd;
    logic ri;
  } modem_status_t;

endpackage

// [core/sync2.sv]
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (ce) begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// [core/modem_tone_line_handshake_regs.sv]
`timescale 1ns/1ps
module modem_tone_line_handshake_regs (
  // clock and control
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // modem (local processor) bus
  input wire logic m_rd,
  input wire logic m_wr,
  input wire logic [2:0] m_addr,
  input wire logic [7:0] m_wdata,
  output logic [7:0] m_rdata,
  // uart (host) bus
  input wire logic u_rd,
  input wire logic u_wr,
  input wire logic [3:0] u_addr,
  input wire logic [7:0] u_wdata,
  output logic [7:0] u_rdata,
  // mode and straps from pins
  input wire logic standalone_strap,
  input wire logic dual_port,
  // transmit conditions from control register zero
  input wire logic tx_enable,
  input wire logic answer_mode,
  // uart core side
  input wire logic uart_txd,
  input wire logic uart_tx_bit_clock,
  input wire logic uart_dtr,
  input wire logic uart_rts,
  output logic uart_rxd,
  output modem_regs_pkg::modem_status_t uart_status,
  // modem datapath
  input wire logic modem_rx_data,
  // external modem-status pins
  input wire modem_regs_pkg::modem_status_t status_pins,
  // serial pins
  input wire logic rxd_pin_in,
  output logic rxd_pin_out,
  output logic rxd_pin_oe_n,
  output logic txd_pin,
  // relay open-drain pin
  output logic hook_pin_out,
  output logic hook_pin_oe_n,
  // to analog section
  output modem_regs_pkg::tx_src_t tx_source,
  output logic [3:0] tone_pair_sel,
  output logic guard_alt,
  output modem_regs_pkg::spk_level_t speaker_level
);
  logic [7:0] tone_r;
  logic [7:0] line_r;
  logic [7:0] scratch_r;
  logic [3:0] hs_status_r;
  logic strap_s;
  logic rxd_s;
  logic uart_tx_bit_clock_s;
  logic [3:0] status_s;
  logic m_hit_tone;
  logic m_hit_line;
  logic m_hit_scr;
  logic m_hit_hs;
  logic u_hit_line;
  logic u_hit_scr;
  logic [7:0] hs_view;
  logic route_uart;
  modem_regs_pkg::tx_src_t src_nxt;
  logic [7:0] m_rdata_nxt;
  logic [7:0] u_rdata_nxt;
  modem_regs_pkg::bus_req_t m_req;
  modem_regs_pkg::bus_req_t u_req;
  modem_regs_pkg::modem_status_t hs_status_map;
  logic txd_dly_r;

  // pin-side inputs cross into clk through two flops
  sync2 #(.W(7)) pin_sync (
    .clk(clk),
    .ce(ce),
    .d({standalone_strap, rxd_pin_in, uart_tx_bit_clock, status_pins}),
    .q({strap_s, rxd_s, uart_tx_bit_clock_s, status_s})
  );

  // each port travels as one request
  always_comb begin
    m_req = '0;
    m_req.rd = m_rd;
    m_req.wr = m_wr;
    m_req.addr = {1'b0, m_addr};
    m_req.wdata = m_wdata;
  end

  always_comb begin
    u_req = '0;
    u_req.rd = u_rd;
    u_req.wr = u_wr;
    u_req.addr = u_addr;
    u_req.wdata = u_wdata;
  end

  assign m_hit_tone = m_req.addr[2:0] == modem_regs_pkg::MADDR_TONE;
  assign m_hit_line = m_req.addr[2:0] == modem_regs_pkg::MADDR_LINE;
  assign m_hit_scr = m_req.addr[2:0] == modem_regs_pkg::MADDR_SCRATCH;
  assign m_hit_hs = m_req.addr[2:0] == modem_regs_pkg::MADDR_HANDSHAKE;
  assign u_hit_line = u_req.addr == modem_regs_pkg::UADDR_LINE;
  assign u_hit_scr = u_req.addr == modem_regs_pkg::UADDR_SCRATCH;

  // reserved register two is not decoded
  always_ff @(posedge clk) begin
    if (ce) begin
      if (!reset_n) begin
        tone_r <= modem_regs_pkg::TONE_RST;
      end else if (m_req.wr && m_hit_tone) begin
        tone_r <= m_req.wdata;
      end
    end
  end

  // both buses reach this register; the modem side wins a collision
  // line writes keep only the used bits
  always_ff @(posedge clk) begin
    if (ce) begin
      if (!reset_n) begin
        line_r <= modem_regs_pkg::LINE_RST;
      end else if (m_req.wr && m_hit_line) begin
        line_r <= m_req.wdata & modem_regs_pkg::LINE_USED_MASK;
      end else if (u_req.wr && u_hit_line) begin
        line_r <= u_req.wdata & modem_regs_pkg::LINE_USED_MASK;
      end
    end
  end

  // one location, modem bus wins a same-cycle collision
  always_ff @(posedge clk) begin
    if (ce) begin
      if (!reset_n) begin
        scratch_r <= modem_regs_pkg::SCRATCH_RST;
      end else if (m_req.wr && m_hit_scr) begin
        scratch_r <= m_req.wdata;
      end else if (u_req.wr && u_hit_scr) begin
        scratch_r <= u_req.wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      if (!reset_n) begin
        hs_status_r <= modem_regs_pkg::HS_STATUS_RST;
      end else if (m_req.wr && m_hit_hs && dual_port) begin
        hs_status_r <= m_req.wdata[modem_regs_pkg::HS_STATUS_W-1:0];
      end
    end
  end

  // register bits d0 to d3 land on the named status lines
  always_comb begin
    hs_status_map = '0;
    hs_status_map.cts = hs_status_r[modem_regs_pkg::HS_CTS_BIT];
    hs_status_map.dsr = hs_status_r[modem_regs_pkg::HS_DSR_BIT];
    hs_status_map.dcd = hs_status_r[modem_regs_pkg::HS_DCD_BIT];
    hs_status_map.ri = hs_status_r[modem_regs_pkg::HS_RI_BIT];
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      if (!reset_n) begin
        uart_status <= '0;
      end else begin
        uart_status <= dual_port ? hs_status_map :
                       modem_regs_pkg::modem_status_t'(status_s);
      end
    end
  end

  // bit seven is the synced clock, two edges behind the uart
  // handshake read view
  always_comb begin
    hs_view = '0;
    hs_view[modem_regs_pkg::HS_STATUS_W-1:0] = hs_status_r;
    hs_view[modem_regs_pkg::HS_DTR_BIT] = uart_dtr;
    hs_view[modem_regs_pkg::HS_RTS_BIT] = uart_rts;
    hs_view[modem_regs_pkg::HS_CLK_BIT] = uart_tx_bit_clock_s;
  end

  always_comb begin
    m_rdata_nxt = '0;
    unique case (m_req.addr[2:0])
      modem_regs_pkg::MADDR_TONE: m_rdata_nxt = tone_r;
      modem_regs_pkg::MADDR_LINE: m_rdata_nxt = line_r;
      modem_regs_pkg::MADDR_SCRATCH: m_rdata_nxt = scratch_r;
      modem_regs_pkg::MADDR_HANDSHAKE: m_rdata_nxt = hs_view;
      default: m_rdata_nxt = '0;
    endcase
  end

  always_comb begin
    u_rdata_nxt = '0;
    unique case (u_req.addr)
      modem_regs_pkg::UADDR_LINE: u_rdata_nxt = line_r;
      modem_regs_pkg::UADDR_SCRATCH: u_rdata_nxt = scratch_r;
      modem_regs_pkg::UADDR_HANDSHAKE: u_rdata_nxt = hs_view;
      default: u_rdata_nxt = '0;
    endcase
  end

  // read data registered, one cycle after the strobe
  // it holds until the next read, so a late sample still sees it
  always_ff @(posedge clk) begin
    if (ce) begin
      if (!reset_n) begin
        m_rdata <= '0;
        u_rdata <= '0;
      end else begin
        if (m_req.rd) begin
          m_rdata <= m_rdata_nxt;
        end
        if (u_req.rd) begin
          u_rdata <= u_rdata_nxt;
        end
      end
    end
  end

  // transmit source priority
  always_comb begin
    src_nxt = modem_regs_pkg::TX_IDLE;
    if (tone_r[modem_regs_pkg::TONE_PAIR_BIT]) begin
      // pair overrides, gated by transmit enable
      if (tx_enable) begin
        src_nxt = modem_regs_pkg::TX_PAIR;
      end
    end else if (tone_r[modem_regs_pkg::TONE_ANSWER_BIT]) begin
      if (tx_enable && answer_mode) begin
        src_nxt = tone_r[modem_regs_pkg::TONE_VARIANT_BIT] ?
                  modem_regs_pkg::ANSWER_TONE_TRANSMIT_2100 :
                  modem_regs_pkg::ANSWER_TONE_TRANSMIT_2225;
      end
    end else if (tone_r[modem_regs_pkg::TONE_GUARD_BIT]) begin
      // guard needs no transmit enable, the bit alone starts it
      // guard tone enable
      src_nxt = modem_regs_pkg::TX_GUARD;
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      if (!reset_n) begin
        tx_source <= modem_regs_pkg::TX_IDLE;
        tone_pair_sel <= '0;
        guard_alt <= 1'b0;
        speaker_level <= modem_regs_pkg::SPK_OFF;
      end else begin
        tx_source <= src_nxt;
        tone_pair_sel <= tone_r[modem_regs_pkg::TONE_SEL_LSB +:
                                modem_regs_pkg::TONE_SEL_W];
        guard_alt <= tone_r[modem_regs_pkg::TONE_VARIANT_BIT];
        speaker_level <= modem_regs_pkg::spk_level_t'(
          line_r[modem_regs_pkg::LINE_VOL_LSB +: 2]);
      end
    end
  end

  // open-drain relay: enable low pulls the pin low
  always_ff @(posedge clk) begin
    if (ce) begin
      if (!reset_n) begin
        hook_pin_out <= 1'b0;
        hook_pin_oe_n <= 1'b1;
      end else begin
        hook_pin_out <= 1'b0;
        hook_pin_oe_n <= !line_r[modem_regs_pkg::LINE_HOOK_BIT];
      end
    end
  end

  assign route_uart = tone_r[modem_regs_pkg::TONE_ROUTE_BIT];

  // a skew here would show a data change before the clock fall
  // uart data delayed to match the synced bit clock
  always_ff @(posedge clk) begin
    if (ce) begin
      if (!reset_n) begin
        txd_dly_r <= 1'b1;
      end else begin
        txd_dly_r <= uart_txd;
      end
    end
  end

  // serial pin routing; mark is high and idles the uart input
  always_ff @(posedge clk) begin
    if (ce) begin
      if (!reset_n) begin
        rxd_pin_out <= 1'b1;
        rxd_pin_oe_n <= 1'b1;
        txd_pin <= 1'b1;
        uart_rxd <= 1'b1;
      end else if (route_uart) begin
        rxd_pin_oe_n <= 1'b1;
        rxd_pin_out <= 1'b1;
        uart_rxd <= rxd_s;
        txd_pin <= txd_dly_r;
      end else if (strap_s) begin
        // input ignored, transmit held at mark
        rxd_pin_oe_n <= 1'b1;
        rxd_pin_out <= 1'b1;
        uart_rxd <= 1'b1;
        txd_pin <= 1'b1;
      end else begin
        rxd_pin_oe_n <= 1'b0;
        rxd_pin_out <= modem_rx_data;
        uart_rxd <= modem_rx_data;
        txd_pin <= txd_dly_r;
      end
    end
  end
endmodule

// [test/modem_regs_assertions.sv]
`timescale 1ns/1ps
module modem_regs_checker (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register buses
  input wire logic m_rd,
  input wire logic m_wr,
  input wire logic [2:0] m_addr,
  input wire logic [7:0] m_wdata,
  input wire logic [7:0] m_rdata,
  input wire logic u_rd,
  input wire logic [3:0] u_addr,
  input wire logic [7:0] u_rdata,
  // side signals
  input wire logic uart_dtr,
  input wire logic hook_pin_out,
  input wire logic hook_pin_oe_n,
  input wire modem_regs_pkg::spk_level_t speaker_level
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire logic [1:0] wvol = m_wdata[7:6];
  wire logic whook = m_wdata[5];
  wire logic lwr = m_wr && m_addr == 3'h5;

  rsv_read_a: assert property (
    m_rd && m_addr == 3'h2 |=> m_rdata == 8'h00) else $error("reserved read");
  u_gap_a: assert property (
    u_rd && u_addr == 4'h0 |=> u_rdata == 8'h00) else $error("unmapped read");
  line_low_a: assert property (
    m_rd && m_addr == 3'h5 |=> m_rdata[4:0] == 5'h00) else $error("line bits");
  hs_gap_a: assert property (
    m_rd && m_addr == 3'h7 |=> !m_rdata[6]) else $error("handshake bit six");
  dtr_mirror_a: assert property (
    m_rd && m_addr == 3'h7 |=> m_rdata[4] == $past(uart_dtr))
    else $error("dtr mirror");
  scratch_share_a: assert property (
    m_wr && m_addr == 3'h6 ##1 u_rd && u_addr == 4'he
    |=> u_rdata == $past(m_wdata, 2)) else $error("scratch not shared");
  volume_set_a: assert property (
    lwr |-> ##2 speaker_level == $past(wvol, 2)) else $error("volume");
  hook_drive_a: assert property (
    lwr |-> ##2 hook_pin_oe_n == !$past(whook, 2)) else $error("hook enable");
  hook_low_a: assert property (
    hook_pin_out == 1'h0) else $error("hook level");

  cover property (m_wr && m_addr == 3'h6 ##1 u_rd && u_addr == 4'he);
  cover property (lwr && whook);
  cover property (m_rd && m_addr == 3'h7);
endmodule

bind modem_tone_line_handshake_regs modem_regs_checker i_modem_regs_checker (
  .clk, .reset_n, .m_rd, .m_wr, .m_addr, .m_wdata, .m_rdata, .u_rd,
  .u_addr, .u_rdata, .uart_dtr, .hook_pin_out, .hook_pin_oe_n,
  .speaker_level);

// [test/uart_core_model.sv]
`timescale 1ns/1ps
module uart_core_model #(
  parameter int HALF = 2
) (
  // clock and control
  input wire logic clk,
  input wire logic run,
  // serial toward the block
  output logic txd,
  output logic bit_clk
);
  int cnt;
  initial begin
    txd = 1'h1;
    bit_clk = 1'h0;
    cnt = 0;
  end
  always @(posedge clk) begin
    if (!run) begin
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      bit_clk <= !bit_clk;
      if (bit_clk) begin
        txd <= !txd;
      end
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// [test/modem_tone_line_handshake_regs_test.sv]
`timescale 1ns/1ps
module modem_tone_line_handshake_regs_test;
  logic clk, reset_n, m_rd, m_wr, u_rd, u_wr, run;
  logic standalone_strap, dual_port, tx_enable, answer_mode;
  logic uart_dtr, uart_rts, modem_rx_data, rxd_pin_in, uart_txd, bit_clk;
  logic uart_rxd, rxd_pin_out, rxd_pin_oe_n, txd_pin;
  logic hook_pin_out, hook_pin_oe_n, guard_alt;
  logic [2:0] m_addr;
  logic [3:0] u_addr, tone_pair_sel;
  logic [7:0] m_wdata, u_wdata, m_rdata, u_rdata;
  modem_regs_pkg::modem_status_t uart_status, status_pins;
  modem_regs_pkg::tx_src_t tx_source;
  modem_regs_pkg::spk_level_t speaker_level;
  int err_total, num_checks;

  modem_tone_line_handshake_regs i_modem_tone_line_handshake_regs (
    .clk, .reset_n, .ce(1'h1), .m_rd, .m_wr, .m_addr, .m_wdata, .m_rdata,
    .u_rd, .u_wr, .u_addr, .u_wdata, .u_rdata, .standalone_strap,
    .dual_port, .tx_enable, .answer_mode, .uart_txd,
    .uart_tx_bit_clock(bit_clk), .uart_dtr, .uart_rts, .uart_rxd,
    .uart_status, .modem_rx_data, .status_pins, .rxd_pin_in, .rxd_pin_out,
    .rxd_pin_oe_n, .txd_pin, .hook_pin_out, .hook_pin_oe_n, .tx_source,
    .tone_pair_sel, .guard_alt, .speaker_level);
  uart_core_model #(.HALF(2)) i_uart_core_model (
    .clk, .run, .txd(uart_txd), .bit_clk);

  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // inputs always move 2 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic mw(input logic [2:0] a, input logic [7:0] d);
    m_wr = 1'h1;
    m_addr = a;
    m_wdata = d;
    tick(1);
    m_wr = 1'h0;
  endtask
  task automatic mr(input logic [2:0] a, input logic [7:0] e);
    m_rd = 1'h1;
    m_addr = a;
    tick(1);
    m_rd = 1'h0;
    chk(m_rdata, e);
  endtask
  task automatic uw(input logic [3:0] a, input logic [7:0] d);
    u_wr = 1'h1;
    u_addr = a;
    u_wdata = d;
    tick(1);
    u_wr = 1'h0;
  endtask
  task automatic ur(input logic [3:0] a, input logic [7:0] e);
    u_rd = 1'h1;
    u_addr = a;
    tick(1);
    u_rd = 1'h0;
    chk(u_rdata, e);
  endtask

  task automatic t_share;
    chk(hook_pin_oe_n, 8'h01);
    mw(3'h6, 8'haa);
    ur(4'he, 8'haa);
    uw(4'he, 8'h55);
    mr(3'h6, 8'h55);
    mw(3'h2, 8'hff);
    mr(3'h2, 8'h00);
    ur(4'h0, 8'h00);
  endtask
  task automatic t_line;
    uw(4'hd, 8'hff);
    mr(3'h5, 8'he0);
    for (int v = 0; v < 4; v++) begin
      mw(3'h5, {v[1:0], v[0], 5'h1f});
      tick(2);
      chk(speaker_level, v[7:0]);
      chk(hook_pin_oe_n, {7'h0, !v[0]});
    end
  endtask
  task automatic t_tone;
    logic [7:0] td [5] = '{8'h20, 8'h21, 8'h40, 8'h41, 8'h35};
    logic [7:0] ts [5] = '{8'h04, 8'h08, 8'h10, 8'h10, 8'h02};
    tx_enable = 1'h1;
    answer_mode = 1'h1;
    for (int i = 0; i < 5; i++) begin
      mw(3'h4, td[i]);
      tick(2);
      chk(tx_source, ts[i]);
      if (td[i][6]) begin
        chk(guard_alt, {7'h0, td[i][0]});
      end
    end
    chk(tone_pair_sel, 8'h05);
    tx_enable = 1'h0;
    tick(2);
    chk(tx_source, 8'h01);
    tx_enable = 1'h1;
    answer_mode = 1'h0;
    mw(3'h4, 8'h20);
    tick(2);
    chk(tx_source, 8'h01);
  endtask
  task automatic t_route;
    mw(3'h4, 8'h00);
    run = 1'h1;
    tick(4);
    run = 1'h0;
    modem_rx_data = 1'h1;
    tick(4);
    chk(rxd_pin_oe_n, 8'h00);
    chk(rxd_pin_out, 8'h01);
    chk(txd_pin, 8'h00);
    standalone_strap = 1'h1;
    tick(5);
    chk(txd_pin, 8'h01);
    chk(rxd_pin_oe_n, 8'h01);
    mw(3'h4, 8'h80);
    rxd_pin_in = 1'h0;
    tick(5);
    chk(uart_rxd, 8'h00);
    chk(txd_pin, 8'h00);
  endtask
  task automatic t_hs;
    dual_port = 1'h1;
    uart_dtr = 1'h1;
    status_pins = 4'h5;
    mw(3'h7, 8'h73);
    tick(2);
    chk(uart_status, 8'h0c);
    ur(4'hf, 8'h13);
    run = 1'h1;
    tick(2);
    run = 1'h0;
    uart_dtr = 1'h0;
    uart_rts = 1'h1;
    tick(4);
    mr(3'h7, 8'ha3);
    dual_port = 1'h0;
    mw(3'h7, 8'h0f);
    tick(4);
    chk(uart_status, 8'h05);
    mr(3'h7, 8'ha3);
  endtask

  initial begin
    {m_rd, m_wr, u_rd, u_wr, run, reset_n} = '0;
    {standalone_strap, dual_port, tx_enable, answer_mode} = '0;
    {uart_dtr, uart_rts, modem_rx_data, status_pins} = '0;
    {m_addr, u_addr, m_wdata, u_wdata} = '0;
    rxd_pin_in = 1'h1;
    err_total = 0;
    num_checks = 0;
    tick(3);
    reset_n = 1'h1;
    t_share;
    t_line;
    t_tone;
    t_route;
    t_hs;
    end_sim;
  end
  // the whole sequence needs well under 300 cycles
  initial begin
    #50us;
    err_total++;
    end_sim;
  end
endmodule
